/* File: rtl/vsc_pkg.sv */
// shared constants, register map and helpers for the vectored source controller
package vsc_pkg;

	// sizes
	localparam int VSC_NUM_SRC = 154;
	localparam int VSC_PRIO_W = 8;
	localparam int VSC_PRIO_BITS = 3;
	localparam int VSC_NEST_DEPTH = 8;

	// usb request position per device class
	localparam int VSC_USB_IDX_CLASS_A = 60;
	localparam int VSC_USB_IDX_CLASS_B = 58;

	// register byte offsets
	localparam logic [7:0] VSC_OFF_CTRL = 8'h00;
	localparam logic [7:0] VSC_OFF_SEL = 8'h04;
	localparam logic [7:0] VSC_OFF_CMD = 8'h08;
	localparam logic [7:0] VSC_OFF_SRC = 8'h0C;
	localparam logic [7:0] VSC_OFF_PRIO = 8'h10;
	localparam logic [7:0] VSC_OFF_THRESH = 8'h14;
	localparam logic [7:0] VSC_OFF_IRQ_STAT = 8'h18;
	localparam logic [7:0] VSC_OFF_IRQ_MASK = 8'h1C;
	localparam logic [7:0] VSC_OFF_ACTIVE = 8'h20;

	// command register bits
	localparam int VSC_CMD_ENABLE = 0;
	localparam int VSC_CMD_DISABLE = 1;
	localparam int VSC_CMD_PEND = 2;
	localparam int VSC_CMD_UNPEND = 3;
	localparam int VSC_CMD_TRIGGER = 4;
	localparam int VSC_CMD_GATE_OPEN = 5;
	localparam int VSC_CMD_GATE_CLOSE = 6;

	// field positions
	localparam int VSC_CTRL_CLOSED = 0;
	localparam int VSC_CTRL_WAS_CLOSED = 1;
	localparam int VSC_SRC_ENABLED = 0;
	localparam int VSC_SRC_PENDING = 1;
	localparam int VSC_SRC_PRIO_LSB = 8;
	localparam int VSC_ACT_REQ = 16;
	localparam int VSC_ACT_SP_LSB = 24;

	// interrupt status bits
	localparam int VSC_EV_W = 2;
	localparam int VSC_EV_TAKEN = 0;
	localparam int VSC_EV_DROP = 1;

	// reset values
	localparam logic VSC_RST_GATE_CLOSED = 1'b1;
	localparam logic [VSC_PRIO_W-1:0] VSC_RST_PRIO = 8'h00;
	localparam logic [VSC_PRIO_W-1:0] VSC_RST_THRESH = 8'h00;

	// arbitration level of an 8-bit priority
	function automatic logic [VSC_PRIO_BITS-1:0] vsc_level(input logic [VSC_PRIO_W-1:0] prio);
		return prio[VSC_PRIO_W-1 -: VSC_PRIO_BITS];
	endfunction

	// zero threshold means no masking
	function automatic logic vsc_thresh_ok(input logic [VSC_PRIO_BITS-1:0] lvl,
		input logic [VSC_PRIO_W-1:0] thresh);
		return (thresh == VSC_RST_THRESH) || (lvl < vsc_level(thresh));
	endfunction

endpackage

/* File: rtl/vsc_prio_mem.sv */
// per-source priority store with registered read port
module vsc_prio_mem import vsc_pkg::*; #(
	parameter int NUM_SRC = VSC_NUM_SRC,
	localparam int SEL_W = $clog2(NUM_SRC)
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// write port
	input wire logic wr_en,
	input wire logic [SEL_W-1:0] wr_idx,
	input wire logic [VSC_PRIO_W-1:0] wr_data,
	// read port
	input wire logic [SEL_W-1:0] rd_idx,
	output logic [VSC_PRIO_W-1:0] rd_data,
	// levels for arbitration
	output logic [NUM_SRC*VSC_PRIO_BITS-1:0] level
);

	typedef struct packed {
		logic [NUM_SRC-1:0][VSC_PRIO_W-1:0] mem;
		logic [VSC_PRIO_W-1:0] rd;
	} vsc_mem_s;

	vsc_mem_s st;
	vsc_mem_s next_st;

	always_comb begin
		next_st = st;
		if (wr_en && (wr_idx <= SEL_W'(NUM_SRC - 1))) begin
			next_st.mem[wr_idx] = wr_data;
		end
		// out-of-range index reads as zero
		next_st.rd = (rd_idx <= SEL_W'(NUM_SRC - 1)) ? st.mem[rd_idx] : VSC_RST_PRIO;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_SRC; i++) begin
			level[i*VSC_PRIO_BITS +: VSC_PRIO_BITS] = vsc_level(st.mem[i]);
		end
	end

	assign rd_data = st.rd;

endmodule

/* File: rtl/vsc_arb.sv */
// picks the most urgent candidate, lowest index on a tie
module vsc_arb import vsc_pkg::*; #(
	parameter int NUM_SRC = VSC_NUM_SRC,
	localparam int SEL_W = $clog2(NUM_SRC)
) (
	// candidates
	input wire logic [NUM_SRC-1:0] cand,
	input wire logic [NUM_SRC*VSC_PRIO_BITS-1:0] level,
	// winner
	output logic found,
	output logic [SEL_W-1:0] best_id,
	output logic [VSC_PRIO_BITS-1:0] best_lvl
);

	always_comb begin
		found = 1'b0;
		best_id = '0;
		best_lvl = '1;
		// downward scan with <= lets the lower index take a tie
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (cand[i] && (!found || level[i*VSC_PRIO_BITS +: VSC_PRIO_BITS] <= best_lvl)) begin
				found = 1'b1;
				best_id = SEL_W'(i);
				best_lvl = level[i*VSC_PRIO_BITS +: VSC_PRIO_BITS];
			end
		end
	end

endmodule

/* File: rtl/vsc_top.sv */
// vectored interrupt source control: enables, pending, priority, global gate
//
// How it works
// - disable command clears controller enable only
// - enable command sets controller enable only
// - enable bit readable per selected source
// - global gate blocks request, enables untouched
// - gate state and prior state readable
// - unpend discards any waiting request
// - pend waits for more urgent handlers
// - disabled pending sources stay waiting
// - per-source priority readable
// - usb index is a variant parameter
// - 8-bit priority, top 3 bits arbitrate
// - equal priority: lowest index wins
// - software trigger acts like line assertion
// - threshold blocks levels at or above
module vsc_top import vsc_pkg::*; #(
	parameter int NUM_SRC = VSC_NUM_SRC,
	parameter int NEST_DEPTH = VSC_NEST_DEPTH,
	parameter bit VARIANT_CLASS_SELECT = 1'b0,
	localparam int SEL_W = $clog2(NUM_SRC),
	localparam int SP_W = $clog2(NEST_DEPTH + 1)
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// source request lines
	input wire logic [NUM_SRC-1:0] src_line,
	input wire logic usb_line,
	// processor side
	output logic irq_req,
	output logic [SEL_W-1:0] irq_id,
	input wire logic irq_ack,
	input wire logic irq_done,
	// event interrupt
	output logic irq_out
);

	localparam int USB_SOURCE_INDEX = VARIANT_CLASS_SELECT ? VSC_USB_IDX_CLASS_B : VSC_USB_IDX_CLASS_A;

	typedef struct packed {
		logic [NUM_SRC-1:0] enable;
		logic [NUM_SRC-1:0] pending;
		logic [NUM_SRC-1:0] line_q;
		logic gate_closed;
		logic was_closed;
		logic [SEL_W-1:0] src_sel;
		logic [VSC_PRIO_W-1:0] thresh;
		logic [VSC_EV_W-1:0] ev_status;
		logic [VSC_EV_W-1:0] ev_mask;
		logic req;
		logic [SEL_W-1:0] req_id;
		logic [VSC_PRIO_BITS-1:0] req_lvl;
		logic [NEST_DEPTH-1:0][VSC_PRIO_BITS-1:0] stack;
		logic [SP_W-1:0] sp;
	} vsc_state_s;

	vsc_state_s st;
	vsc_state_s next_st;

	logic acc;
	logic wr;
	logic setup;
	logic sel_ok;
	logic [NUM_SRC-1:0] sel_vec;
	logic [NUM_SRC-1:0] line;
	logic [NUM_SRC-1:0] cand;
	logic [NUM_SRC*VSC_PRIO_BITS-1:0] level;
	logic [VSC_PRIO_W-1:0] prio_rd;
	logic found;
	logic [SEL_W-1:0] best_id;
	logic [VSC_PRIO_BITS-1:0] best_lvl;
	logic more_urgent;
	logic ack;
	logic prio_wr;

	////////////////////////////////////////////////////////////////////////
	// decode

	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign setup = psel && !penable;
	assign sel_ok = st.src_sel <= SEL_W'(NUM_SRC - 1);
	assign sel_vec = sel_ok ? (NUM_SRC'(1) << st.src_sel) : '0;
	assign prio_wr = wr && (paddr == VSC_OFF_PRIO);
	assign ack = irq_ack && irq_req;

	always_comb begin
		line = src_line;
		line[USB_SOURCE_INDEX] = src_line[USB_SOURCE_INDEX] | usb_line;
	end

	////////////////////////////////////////////////////////////////////////
	// priority store and arbitration

	vsc_prio_mem #(.NUM_SRC(NUM_SRC)) u_prio (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(prio_wr),
		.wr_idx(st.src_sel),
		.wr_data(pwdata[VSC_PRIO_W-1:0]),
		.rd_idx(st.src_sel),
		.rd_data(prio_rd),
		.level(level)
	);

	// only enabled, unmasked pending sources compete
	always_comb begin
		for (int i = 0; i < NUM_SRC; i++) begin
			cand[i] = st.pending[i] && st.enable[i]
				&& vsc_thresh_ok(level[i*VSC_PRIO_BITS +: VSC_PRIO_BITS], st.thresh);
		end
	end

	// top bits arbitrate, lowest index on tie
	vsc_arb #(.NUM_SRC(NUM_SRC)) u_arb (
		.cand(cand),
		.level(level),
		.found(found),
		.best_id(best_id),
		.best_lvl(best_lvl)
	);

	// same or lower urgency waits for the running handler
	assign more_urgent = (st.sp == '0) || (best_lvl < st.stack[st.sp - SP_W'(1)]);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [NUM_SRC-1:0] set_pend;
		logic [NUM_SRC-1:0] clr_pend;
		logic [NUM_SRC-1:0] set_en;
		logic [NUM_SRC-1:0] clr_en;
		logic [VSC_EV_W-1:0] ev_set;
		logic cmd_wr;
		set_pend = '0;
		clr_pend = '0;
		set_en = '0;
		clr_en = '0;
		ev_set = '0;
		cmd_wr = wr && (paddr == VSC_OFF_CMD);
		next_st = st;
		next_st.line_q = line;

		// line edge, pend and trigger all set pending
		set_pend = line & ~st.line_q;
		if (cmd_wr && (pwdata[VSC_CMD_PEND] || pwdata[VSC_CMD_TRIGGER])) begin
			set_pend = set_pend | sel_vec;
		end
		if (cmd_wr && pwdata[VSC_CMD_UNPEND]) begin
			clr_pend = sel_vec;
			ev_set[VSC_EV_DROP] = |(st.pending & sel_vec);
		end
		if (ack) begin
			clr_pend = clr_pend | (NUM_SRC'(1) << st.req_id);
			ev_set[VSC_EV_TAKEN] = 1'b1;
		end
		// a new assertion in the clearing cycle is kept
		next_st.pending = (st.pending & ~clr_pend) | set_pend;

		// controller enables, peripheral enables live elsewhere
		if (cmd_wr && pwdata[VSC_CMD_DISABLE]) begin
			clr_en = sel_vec;
		end
		if (cmd_wr && pwdata[VSC_CMD_ENABLE]) begin
			set_en = sel_vec;
		end
		next_st.enable = (st.enable & ~clr_en) | set_en;

		// gate touches no enable, prior state kept
		if (cmd_wr && (pwdata[VSC_CMD_GATE_OPEN] || pwdata[VSC_CMD_GATE_CLOSE])) begin
			next_st.was_closed = st.gate_closed;
			// closing wins so a racing pair stays safe
			next_st.gate_closed = pwdata[VSC_CMD_GATE_CLOSE];
		end

		if (wr && (paddr == VSC_OFF_SEL)) begin
			next_st.src_sel = pwdata[SEL_W-1:0];
		end
		if (wr && (paddr == VSC_OFF_THRESH)) begin
			next_st.thresh = pwdata[VSC_PRIO_W-1:0];
		end
		if (wr && (paddr == VSC_OFF_IRQ_MASK)) begin
			next_st.ev_mask = pwdata[VSC_EV_W-1:0];
		end
		// write one to clear, a same-cycle event wins
		if (wr && (paddr == VSC_OFF_IRQ_STAT)) begin
			next_st.ev_status = st.ev_status & ~pwdata[VSC_EV_W-1:0];
		end
		next_st.ev_status = next_st.ev_status | ev_set;

		// active handler levels
		unique case ({ack, irq_done})
			2'b10: begin
				if (st.sp != SP_W'(NEST_DEPTH)) begin
					next_st.stack[st.sp] = st.req_lvl;
					next_st.sp = st.sp + SP_W'(1);
				end
			end
			2'b01: begin
				if (st.sp != '0) begin
					next_st.sp = st.sp - SP_W'(1);
				end
			end
			2'b11: begin
				if (st.sp != '0) begin
					next_st.stack[st.sp - SP_W'(1)] = st.req_lvl;
				end else begin
					next_st.stack[0] = st.req_lvl;
					next_st.sp = SP_W'(1);
				end
			end
			2'b00: begin
			end
		endcase

		// one dead cycle after accept so stale pending is not offered twice
		next_st.req = found && more_urgent && !ack;
		next_st.req_id = best_id;
		next_st.req_lvl = best_lvl;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.gate_closed <= VSC_RST_GATE_CLOSED;
			st.was_closed <= VSC_RST_GATE_CLOSED;
			st.thresh <= VSC_RST_THRESH;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// recheck live state so a late disable or close holds the request
	assign irq_req = st.req && st.enable[st.req_id] && st.pending[st.req_id]
		&& !st.gate_closed && vsc_thresh_ok(st.req_lvl, st.thresh);
	assign irq_id = st.req_id;
	assign irq_out = |(st.ev_status & st.ev_mask);
	assign pready = 1'b1;

	always_comb begin
		prdata = '0;
		pslverr = 1'b0;
		unique case (paddr)
			VSC_OFF_CTRL: begin
				prdata[VSC_CTRL_CLOSED] = st.gate_closed;
				prdata[VSC_CTRL_WAS_CLOSED] = st.was_closed;
			end
			VSC_OFF_SEL: prdata[SEL_W-1:0] = st.src_sel;
			VSC_OFF_CMD: begin
			end
			VSC_OFF_SRC: begin
				prdata[VSC_SRC_ENABLED] = |(st.enable & sel_vec);
				prdata[VSC_SRC_PENDING] = |(st.pending & sel_vec);
				prdata[VSC_SRC_PRIO_LSB +: VSC_PRIO_W] = prio_rd;
			end
			VSC_OFF_PRIO: prdata[VSC_PRIO_W-1:0] = prio_rd;
			VSC_OFF_THRESH: prdata[VSC_PRIO_W-1:0] = st.thresh;
			VSC_OFF_IRQ_STAT: prdata[VSC_EV_W-1:0] = st.ev_status;
			VSC_OFF_IRQ_MASK: prdata[VSC_EV_W-1:0] = st.ev_mask;
			VSC_OFF_ACTIVE: begin
				prdata[SEL_W-1:0] = st.req_id;
				prdata[VSC_ACT_REQ] = irq_req;
				prdata[VSC_ACT_SP_LSB +: SP_W] = st.sp;
			end
			default: pslverr = acc;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic cmd_now;
	assign cmd_now = wr && (paddr == VSC_OFF_CMD) && sel_ok;

	chk_disable_clears: assert property (cmd_now && pwdata[VSC_CMD_DISABLE] && !pwdata[VSC_CMD_ENABLE]
		|=> !st.enable[$past(st.src_sel)]) else $error("disable did not clear enable");
	chk_enable_sets: assert property (cmd_now && pwdata[VSC_CMD_ENABLE]
		|=> st.enable[$past(st.src_sel)]) else $error("enable did not set enable");
	chk_enable_read: assert property (acc && !pwrite && paddr == VSC_OFF_SRC && sel_ok
		|-> prdata[VSC_SRC_ENABLED] == st.enable[st.src_sel]) else $error("enable readback wrong");
	chk_gate_keeps_en: assert property (cmd_now && (pwdata[VSC_CMD_GATE_OPEN] || pwdata[VSC_CMD_GATE_CLOSE])
		&& !pwdata[VSC_CMD_ENABLE] && !pwdata[VSC_CMD_DISABLE] |=> $stable(st.enable))
		else $error("gate command changed enables");
	chk_gate_blocks: assert property (st.gate_closed |-> !irq_req) else $error("request while gate closed");
	chk_gate_history: assert property (cmd_now && pwdata[VSC_CMD_GATE_CLOSE]
		|=> st.was_closed == $past(st.gate_closed) && st.gate_closed) else $error("gate history wrong");
	chk_unpend_drops: assert property (cmd_now && pwdata[VSC_CMD_UNPEND] && !pwdata[VSC_CMD_PEND]
		&& !pwdata[VSC_CMD_TRIGGER] && !(line[st.src_sel] && !st.line_q[st.src_sel])
		|=> !st.pending[$past(st.src_sel)]) else $error("unpend left pending");
	chk_pend_marks: assert property (cmd_now && (pwdata[VSC_CMD_PEND] || pwdata[VSC_CMD_TRIGGER])
		|=> st.pending[$past(st.src_sel)]) else $error("pend not recorded");
	// no dispatch at or above the running level
	chk_no_preempt_eq: assert property (irq_req && st.sp != '0
		|-> $past(best_lvl) < $past(st.stack[st.sp - SP_W'(1)])) else $error("dispatch not more urgent");
	chk_enabled_only: assert property (irq_req |-> st.enable[irq_id] && st.pending[irq_id])
		else $error("disabled source dispatched");
	chk_thresh_mask: assert property (irq_req && st.thresh != VSC_RST_THRESH
		|-> st.req_lvl < vsc_level(st.thresh)) else $error("masked level dispatched");
	// accept clears pending and drops request, unless set again in that cycle
	chk_ack_clears: assert property (ack && !(line[irq_id] && !st.line_q[irq_id])
		&& !(cmd_now && (pwdata[VSC_CMD_PEND] || pwdata[VSC_CMD_TRIGGER]) && st.src_sel == irq_id)
		|=> !irq_req && !st.pending[$past(irq_id)]) else $error("accept did not clear");

	cov_dispatch: cover property (irq_req ##1 irq_ack && irq_req);
	cov_nested: cover property (st.sp == SP_W'(2));
	cov_drop: cover property (st.ev_status[VSC_EV_DROP] && irq_out);
	cov_masked_wait: cover property (found && !more_urgent && st.sp != '0);

endmodule

/* File: bench/vsc_cpu_model.sv */
// processor model that accepts the single prioritized request
module vsc_cpu_model import vsc_pkg::*; #(
	parameter int SEL_W = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench controls
	input wire logic auto_take,
	input wire logic [3:0] take_dly,
	input wire logic ret,
	// controller link
	input wire logic irq_req,
	input wire logic [SEL_W-1:0] irq_id,
	output logic irq_ack,
	output logic irq_done,
	// observed acceptances
	output logic [SEL_W-1:0] taken_id,
	output int taken_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	// ack is held off take_dly cycles to act as a slow core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ack <= 1'b0;
			irq_done <= 1'b0;
			cnt <= 4'h0;
			taken_id <= '0;
			taken_cnt <= 0;
		end else begin
			irq_done <= ret;
			irq_ack <= 1'b0;
			cnt <= 4'h0;
			if (irq_ack && irq_req) begin
				taken_id <= irq_id;
				taken_cnt <= taken_cnt + 1;
			end else if (auto_take && irq_req && !irq_ack) begin
				if (cnt == take_dly) begin
					irq_ack <= 1'b1;
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	end
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the vectored source controller
module testbench import vsc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
	logic usb_line, irq_req, irq_ack, irq_done, irq_out, auto_take, ret;
	logic [3:0] take_dly;
	logic [7:0] paddr, irq_id, taken_id;
	logic [31:0] pwdata, prdata, rdat;
	logic [VSC_NUM_SRC-1:0] src_line;
	int taken_cnt, err_total, checks_done, cyc, n0;
	vsc_top i_vsc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.src_line(src_line), .usb_line(usb_line), .irq_req(irq_req), .irq_id(irq_id),
		.irq_ack(irq_ack), .irq_done(irq_done), .irq_out(irq_out));
	vsc_cpu_model i_vsc_cpu_model (.pclk(pclk), .presetn(presetn), .auto_take(auto_take),
		.take_dly(take_dly), .ret(ret), .irq_req(irq_req), .irq_id(irq_id), .irq_ack(irq_ack),
		.irq_done(irq_done), .taken_id(taken_id), .taken_cnt(taken_cnt));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			end_sim();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done = checks_done + 1;
		if (s !== e) begin
			err_total = err_total + 1;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// one edge of gap first, so back-to-back calls never reassign psel in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cmd(input int s, input int b);
		apb(1'b1, VSC_OFF_SEL, 32'(s));
		apb(1'b1, VSC_OFF_CMD, 32'h1 << b);
	endtask
	task automatic take(input logic [7:0] id);
		n0 = n0 + 1;
		for (int i = 0; i < 40 && taken_cnt < n0; i++) @(posedge pclk);
		chk("taken count", taken_cnt, n0);
		chk("taken id", {24'h0, taken_id}, {24'h0, id});
	endtask
	task automatic done;
		ret <= 1'b1;
		@(posedge pclk);
		ret <= 1'b0;
		@(posedge pclk);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_enable;
		apb(1'b0, VSC_OFF_CTRL, 32'h0);
		chk("ctrl reset", rdat, 32'h3);
		apb(1'b0, 8'h24, 32'h0);
		chk("unmapped err", {31'h0, slv}, 32'h1);
		chk("pready", {31'h0, pready}, 32'h1);
		chk("unmapped data", rdat, 32'h0);
		cmd(5, VSC_CMD_ENABLE);
		apb(1'b0, VSC_OFF_SRC, 32'h0);
		chk("enabled", rdat, 32'h1);
		cmd(5, VSC_CMD_DISABLE);
		apb(1'b0, VSC_OFF_SRC, 32'h0);
		chk("disabled", rdat, 32'h0);
	endtask
	task automatic t_gate;
		cmd(5, VSC_CMD_ENABLE);
		cmd(5, VSC_CMD_GATE_OPEN);
		apb(1'b0, VSC_OFF_CTRL, 32'h0);
		chk("gate open", rdat, 32'h2);
		cmd(5, VSC_CMD_GATE_CLOSE);
		apb(1'b0, VSC_OFF_CTRL, 32'h0);
		chk("gate closed", rdat, 32'h1);
		cmd(5, VSC_CMD_PEND);
		apb(1'b0, VSC_OFF_SRC, 32'h0);
		chk("enable kept", rdat, 32'h3);
		chk("gated req", {31'h0, irq_req}, 32'h0);
		cmd(5, VSC_CMD_GATE_OPEN);
		take(8'd5);
		done();
		chk("irq masked", {31'h0, irq_out}, 32'h0);
		apb(1'b1, VSC_OFF_IRQ_MASK, 32'h1);
		apb(1'b0, VSC_OFF_IRQ_STAT, 32'h0);
		chk("stat taken", rdat, 32'h1);
		chk("irq raised", {31'h0, irq_out}, 32'h1);
		apb(1'b1, VSC_OFF_IRQ_STAT, 32'h1);
		@(posedge pclk);
		chk("irq cleared", {31'h0, irq_out}, 32'h0);
		cmd(5, VSC_CMD_DISABLE);
	endtask
	task automatic t_pend;
		cmd(9, VSC_CMD_PEND);
		repeat (6) @(posedge pclk);
		chk("pend disabled", taken_cnt, n0);
		apb(1'b0, VSC_OFF_SRC, 32'h0);
		chk("pend waits", rdat, 32'h2);
		cmd(9, VSC_CMD_ENABLE);
		take(8'd9);
		apb(1'b0, VSC_OFF_SRC, 32'h0);
		chk("ack clears", rdat, 32'h1);
		done();
		take_dly <= 4'h3;
		cmd(9, VSC_CMD_TRIGGER);
		take(8'd9);
		done();
		take_dly <= 4'h0;
		cmd(9, VSC_CMD_DISABLE);
		cmd(11, VSC_CMD_PEND);
		cmd(11, VSC_CMD_UNPEND);
		apb(1'b0, VSC_OFF_SRC, 32'h0);
		chk("unpended", rdat, 32'h0);
		apb(1'b0, VSC_OFF_IRQ_STAT, 32'h0);
		chk("stat drop", {31'h0, rdat[1]}, 32'h1);
		cmd(11, VSC_CMD_ENABLE);
		repeat (6) @(posedge pclk);
		chk("no dispatch", taken_cnt, n0);
		cmd(11, VSC_CMD_DISABLE);
	endtask
	task automatic t_prio;
		int ids[3] = '{3, 20, 21};
		logic [7:0] pr[3] = '{8'h67, 8'h5F, 8'h40};
		for (int k = 0; k < 3; k++) begin
			cmd(ids[k], VSC_CMD_ENABLE);
			apb(1'b1, VSC_OFF_PRIO, {24'h0, pr[k]});
			apb(1'b0, VSC_OFF_SRC, 32'h0);
			chk("src prio", rdat, {16'h0, pr[k], 8'h01});
			apb(1'b0, VSC_OFF_PRIO, 32'h0);
			chk("prio read", rdat, {24'h0, pr[k]});
		end
		auto_take <= 1'b0;
		src_line[3] <= 1'b1;
		src_line[20] <= 1'b1;
		src_line[21] <= 1'b1;
		for (int i = 0; i < 20 && irq_req !== 1'b1; i++) @(posedge pclk);
		chk("tie winner", {24'h0, irq_id}, 32'd20);
		apb(1'b0, VSC_OFF_ACTIVE, 32'h0);
		chk("active req", rdat, 32'h00010014);
		auto_take <= 1'b1;
		take(8'd20);
		repeat (6) @(posedge pclk);
		chk("no preempt", taken_cnt, n0);
		apb(1'b0, VSC_OFF_ACTIVE, 32'h0);
		chk("active nested", rdat, 32'h01000015);
		done();
		take(8'd21);
		done();
		take(8'd3);
		done();
		src_line[3] <= 1'b0;
		repeat (2) @(posedge pclk);
		src_line[3] <= 1'b1;
		take(8'd3);
		done();
		src_line <= '0;
	endtask
	task automatic t_thresh;
		cmd(30, VSC_CMD_ENABLE);
		apb(1'b1, VSC_OFF_PRIO, 32'h40);
		apb(1'b1, VSC_OFF_THRESH, 32'h40);
		cmd(30, VSC_CMD_PEND);
		repeat (6) @(posedge pclk);
		chk("thresh blocks", taken_cnt, n0);
		apb(1'b1, VSC_OFF_THRESH, 32'h60);
		apb(1'b0, VSC_OFF_THRESH, 32'h0);
		chk("thresh read", rdat, 32'h60);
		take(8'd30);
		done();
		apb(1'b1, VSC_OFF_PRIO, 32'hE0);
		apb(1'b1, VSC_OFF_THRESH, 32'h0);
		cmd(30, VSC_CMD_PEND);
		take(8'd30);
		done();
		cmd(30, VSC_CMD_DISABLE);
		usb_line <= 1'b1;
		apb(1'b1, VSC_OFF_SEL, VSC_USB_IDX_CLASS_A);
		apb(1'b0, VSC_OFF_SRC, 32'h0);
		chk("usb index", rdat, 32'h2);
		apb(1'b1, VSC_OFF_SEL, VSC_USB_IDX_CLASS_B);
		apb(1'b0, VSC_OFF_SRC, 32'h0);
		chk("usb other", rdat, 32'h0);
	endtask
	initial begin
		{presetn, psel, penable, pwrite, usb_line, auto_take, ret} = 7'h02;
		paddr = 8'h00;
		pwdata = 32'h0;
		take_dly = 4'h0;
		src_line = '0;
		{err_total, checks_done, cyc, n0} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_enable();
		t_gate();
		t_pend();
		t_prio();
		t_thresh();
		end_sim();
	end
endmodule
